// ==== common/rsc_pkg.sv ====
// Constants, types and reset state of the rheostat serial command unit.
// Assumes a single 100 MHz system clock; serial pins arrive asynchronously.
//
// Overview of operation
// R1: Frame is 16 bits: two unused bits, 4-bit command, 10-bit data.
// R2: Host sends MSB first from bit 15, unused leading bits as zero.
// R3: Frame sync low for the whole word; command runs when it rises.
// R4: Clocks counted in 16-bit multiples; 32 bits valid, odd lengths not.
// R5: Serial clock may stop while frame sync is high.
// R6: Low-resolution variant ignores two wiper LSBs on write and read.
// R7: NOP command does nothing and ignores its data.
// R8: Command 1 loads data into wiper register when write enable set.
// R9: Command 2 returns wiper in last 10 clocks of next frame.
// R10: Command 3 stores wiper at next OTP location from 0x01, 50 entries.
// R11: During the 350 ms store the shift register is locked.
// R12: Store completion shown in program-ok bit, polled via control read.
// R13: Command 4 reloads wiper from last stored value, even if protected.
// R14: Command 5 returns OTP entry selected by data bits 5..0 next frame.
// R15: Command 6 returns address of last programmed OTP entry next frame.
// R16: Command 7 writes data bits 2..0 into control register.
// R17: Command 8 returns control register contents next frame.
// R18: Command 9 enters shutdown when data bit 0 is 1, leaves when 0.
// R19: Wiper write enable clears at power-up; only reload may change wiper.
// R20: Store refused unless program enable set; that bit resets to 0.
// R21: Power-up wiper is midscale if nothing stored, else last stored value; reset here clears storage, so always midscale.
// R22: Serial input sampled on each serial clock falling edge while framed.
// R23: Frame sync rising before sixteenth clock abandons frame, no change.
// R24: Serial output is open drain and needs an external pull-up.
// R25: Program-ok set after successful store, zero by default or on failure.
// R26: Command codes 10 to 15 act as NOP and change nothing.

package rsc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PROG_TIME_MS = 350;
    localparam int unsigned PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

    // ----------------------------------------
    // Frame layout
    // ----------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 10;
    localparam int CMD_LSB = 10;
    localparam int CMD_MSB = 13;
    localparam int OTP_ENTRIES = 50;
    localparam logic [5:0] OTP_LAST = 6'h32;
    localparam logic [9:0] WIPER_MIDSCALE = 10'h200;

    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WRITE_WIPER = 4'h1;
    localparam logic [3:0] CMD_READ_WIPER = 4'h2;
    localparam logic [3:0] CMD_STORE = 4'h3;
    localparam logic [3:0] CMD_RELOAD = 4'h4;
    localparam logic [3:0] CMD_READ_OTP = 4'h5;
    localparam logic [3:0] CMD_READ_ADDR = 4'h6;
    localparam logic [3:0] CMD_WRITE_CTRL = 4'h7;
    localparam logic [3:0] CMD_READ_CTRL = 4'h8;
    localparam logic [3:0] CMD_SHUTDOWN = 4'h9;

    // Control register bits
    localparam int CTL_PROG_EN = 0;
    localparam int CTL_WRITE_EN = 1;
    localparam int CTL_CAL_DIS = 2;
    localparam int CTL_PROG_OK = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // ----------------------------------------
    // AXI4-Lite register map
    // ----------------------------------------
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam int ST_WIPER_LSB = 0;
    localparam int ST_CTRL_LSB = 12;
    localparam int ST_SHUTDOWN = 16;
    localparam int ST_BUSY = 17;
    localparam int ST_LAST_LSB = 24;
    localparam int CFG_LOWRES = 0;
    localparam int CFG_FAIL = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pin sync reset: frame sync idles high
    localparam logic [2:0] PIN_IDLE = 3'h2;

    typedef struct packed {
        logic awvalid;
        logic [AXI_AW-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_AW-1:0] araddr;
        logic rready;
    } rsc_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } rsc_axi_rsp_type;

    typedef enum logic [1:0] {LS_IDLE, LS_FRAME, LS_LOCKED} rsc_link_state_type;

    typedef struct packed {
        rsc_link_state_type lstate;
        logic prev_sclk;
        logic prev_fsn;
        logic [15:0] shift;
        logic [3:0] cnt;
        logic seen16;
        logic [15:0] oshift;
        logic [15:0] oword;
        logic sdo_oe_n;
        logic serial_out;
        logic [9:0] wiper;
        logic [3:0] ctrl;
        logic shutdown;
        logic busy;
        logic [31:0] timer;
        logic [5:0] last_addr;
        logic [OTP_ENTRIES-1:0][9:0] mem;
        logic lowres;
        logic fail_inj;
        logic aw_got;
        logic w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        rsc_axi_rsp_type axi;
    } rsc_state_type;

    localparam rsc_state_type STATE_RESET = '{
        lstate: LS_IDLE,
        prev_fsn: 1'b1,
        sdo_oe_n: 1'b1,
        wiper: WIPER_MIDSCALE,
        ctrl: CTRL_RESET,
        axi: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        default: '0
    };

endpackage

// ==== hw/rsc_sync3.sv ====
// Three-stage synchroniser for asynchronous pins.
// Assumes clk_sys domain; filtered output moves only when stages two and three agree.
`timescale 1ns/10ps

module rsc_sync3 #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] filt_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] filt;
    } rsc_sync_state_type;

    rsc_sync_state_type q, d;

    always_comb begin
        d = q;
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        // Stage one feeds stage two only, never a decision
        for (int i = 0; i < W; i++) begin
            if (q.s2[i] == q.s3[i]) begin
                d.filt[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '{s1: INIT, s2: INIT, s3: INIT, filt: INIT};
        end else if (ce) begin
            q <= d;
        end
    end

    assign filt_o = q.filt;

endmodule // rsc_sync3

// ==== hw/rsc_top.sv ====
// Serial command unit of a digital rheostat with an AXI4-Lite status port.
// Assumes serial pins are asynchronous to clk_sys and sclk is much slower than it.
`timescale 1ns/10ps

module rsc_top #(
    parameter int unsigned PROG_CYCLES = rsc_pkg::PROG_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire rsc_pkg::rsc_axi_req_type axi_req,
    output rsc_pkg::rsc_axi_rsp_type axi_rsp,
    input wire logic sclk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    input wire logic serial_out_i,
    output logic serial_out_o,
    output logic serial_out_oe_n,
    output logic [9:0] wiper_o,
    output logic shutdown_o,
    output logic tolerance_calib_disable_o,
    output logic busy_o
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [2:0] pins;

    rsc_sync3 #(
        .W(3),
        .INIT(rsc_pkg::PIN_IDLE)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .async_i({serial_in, frame_sync_n, sclk}),
        .filt_o(pins)
    );

    rsc_pkg::rsc_state_type q, d;
    logic sclk_f, fsn_f, sin_f;
    logic sclk_fall, fs_fall, fs_rise;
    logic frame_ok, exec;
    logic [3:0] cmd;
    logic [9:0] data;
    logic [9:0] wiper_rd;
    logic [5:0] otp_idx;

    assign sclk_f = pins[0];
    assign fsn_f = pins[1];
    assign sin_f = pins[2];
    assign sclk_fall = q.prev_sclk && !sclk_f;
    assign fs_fall = q.prev_fsn && !fsn_f;
    assign fs_rise = !q.prev_fsn && fsn_f;
    // Only whole multiples of sixteen clocks execute
    assign frame_ok = q.seen16 && (q.cnt == 4'h0); // R4 R23
    assign exec = ce && (q.lstate == rsc_pkg::LS_FRAME) && fs_rise && frame_ok; // R3
    assign cmd = q.shift[rsc_pkg::CMD_MSB:rsc_pkg::CMD_LSB]; // R1
    assign data = q.shift[rsc_pkg::DATA_BITS-1:0]; // R1
    assign wiper_rd = q.lowres ? {q.wiper[9:2], 2'h0} : q.wiper; // R6
    assign otp_idx = data[5:0];

    // All state below moves in one process, so no flag has two writers

    always_comb begin
        d = q;
        d.prev_sclk = sclk_f;
        d.prev_fsn = fsn_f;

        // ----------------------------------------
        // Serial link
        // ----------------------------------------
        case (q.lstate)
            rsc_pkg::LS_IDLE: begin
                // Sclk edges are ignored here, so a stopped clock is harmless
                if (fs_fall) begin // R5
                    d.cnt = 4'h0;
                    d.seen16 = 1'b0;
                    d.oshift = q.oword;
                    // A locked frame leaves the line released throughout
                    d.sdo_oe_n = q.busy | q.oword[15]; // R24 R11
                    d.lstate = q.busy ? rsc_pkg::LS_LOCKED : rsc_pkg::LS_FRAME; // R11
                end
            end
            rsc_pkg::LS_FRAME: begin
                if (fs_rise) begin
                    d.lstate = rsc_pkg::LS_IDLE;
                    d.sdo_oe_n = 1'b1;
                end else if (sclk_fall) begin
                    d.shift = {q.shift[14:0], sin_f}; // R22 R2
                    d.cnt = q.cnt + 4'h1; // R4
                    if (q.cnt == 4'hf) begin
                        d.seen16 = 1'b1;
                    end
                    // Daisy-chain style: received bits follow the answer word
                    d.oshift = {q.oshift[14:0], sin_f};
                    d.sdo_oe_n = q.oshift[14]; // R24
                end
            end
            rsc_pkg::LS_LOCKED: begin
                // Frames arriving during a store are discarded whole
                if (fs_rise) begin // R11
                    d.lstate = rsc_pkg::LS_IDLE;
                end
            end
            default: begin
                d.lstate = rsc_pkg::LS_IDLE;
            end
        endcase

        // ----------------------------------------
        // Command execution
        // ----------------------------------------
        if (exec) begin
            d.oword = q.shift;
            case (cmd)
                rsc_pkg::CMD_WRITE_WIPER: begin
                    if (q.ctrl[rsc_pkg::CTL_WRITE_EN]) begin // R8 R19
                        d.wiper = q.lowres ? {data[9:2], 2'h0} : data; // R6
                    end
                end
                rsc_pkg::CMD_READ_WIPER: begin
                    d.oword = {6'h0, wiper_rd}; // R9
                end
                rsc_pkg::CMD_STORE: begin
                    d.ctrl[rsc_pkg::CTL_PROG_OK] = 1'b0; // R25
                    if (q.ctrl[rsc_pkg::CTL_PROG_EN] && !q.fail_inj &&
                            q.last_addr < rsc_pkg::OTP_LAST) begin // R20 R10
                        d.busy = 1'b1; // R11
                        d.timer = 32'h0;
                    end
                end
                rsc_pkg::CMD_RELOAD: begin
                    // Reload ignores write protection
                    d.wiper = (q.last_addr == 6'h0) ? rsc_pkg::WIPER_MIDSCALE
                            : q.mem[q.last_addr - 6'h1]; // R13 R21
                    d.shutdown = 1'b0;
                end
                rsc_pkg::CMD_READ_OTP: begin
                    if (otp_idx != 6'h0 && otp_idx <= rsc_pkg::OTP_LAST) begin // R14
                        d.oword = {6'h0, q.mem[otp_idx - 6'h1]};
                    end else begin
                        d.oword = 16'h0;
                    end
                end
                rsc_pkg::CMD_READ_ADDR: begin
                    d.oword = {10'h0, q.last_addr}; // R15
                end
                rsc_pkg::CMD_WRITE_CTRL: begin
                    d.ctrl[2:0] = data[2:0]; // R16
                end
                rsc_pkg::CMD_READ_CTRL: begin
                    d.oword = {12'h0, q.ctrl}; // R17 R12
                end
                rsc_pkg::CMD_SHUTDOWN: begin
                    d.shutdown = data[0]; // R18
                end
                default: begin
                    // NOP and undefined codes change nothing
                end // R7 R26
            endcase
        end

        // ----------------------------------------
        // OTP programming timer
        // ----------------------------------------
        if (q.busy) begin
            d.timer = q.timer + 32'h1;
            if (q.timer == PROG_CYCLES - 1) begin
                d.busy = 1'b0;
                d.mem[q.last_addr] = q.wiper; // R10
                d.last_addr = q.last_addr + 6'h1; // R10
                d.ctrl[rsc_pkg::CTL_PROG_OK] = 1'b1; // R25 R12
            end
        end

        // ----------------------------------------
        // AXI4-Lite write
        // ----------------------------------------
        if (axi_req.awvalid && q.axi.awready) begin
            d.axi.awready = 1'b0;
            d.aw_got = 1'b1;
            d.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.axi.wready) begin
            d.axi.wready = 1'b0;
            d.w_got = 1'b1;
            d.wdata = axi_req.wdata;
            d.wstrb = axi_req.wstrb;
        end
        if (q.aw_got && q.w_got && !q.axi.bvalid) begin
            d.axi.bvalid = 1'b1;
            if (q.awaddr == rsc_pkg::REG_CONFIG) begin
                d.axi.bresp = rsc_pkg::RESP_OKAY;
                if (q.wstrb[0]) begin
                    d.lowres = q.wdata[rsc_pkg::CFG_LOWRES];
                    d.fail_inj = q.wdata[rsc_pkg::CFG_FAIL];
                end
            end else begin
                // Status is read-only, anything else is unmapped
                d.axi.bresp = rsc_pkg::RESP_SLVERR;
            end
        end
        if (q.axi.bvalid && axi_req.bready) begin
            d.axi.bvalid = 1'b0;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.axi.awready = 1'b1;
            d.axi.wready = 1'b1;
        end

        // ----------------------------------------
        // AXI4-Lite read
        // ----------------------------------------
        if (axi_req.arvalid && q.axi.arready) begin
            d.axi.arready = 1'b0;
            d.axi.rvalid = 1'b1;
            d.axi.rdata = 32'h0;
            d.axi.rresp = rsc_pkg::RESP_OKAY;
            if (axi_req.araddr == rsc_pkg::REG_STATUS) begin
                d.axi.rdata[rsc_pkg::ST_WIPER_LSB +: 10] = wiper_rd;
                d.axi.rdata[rsc_pkg::ST_CTRL_LSB +: 4] = q.ctrl;
                d.axi.rdata[rsc_pkg::ST_SHUTDOWN] = q.shutdown;
                d.axi.rdata[rsc_pkg::ST_BUSY] = q.busy;
                d.axi.rdata[rsc_pkg::ST_LAST_LSB +: 6] = q.last_addr;
            end else if (axi_req.araddr == rsc_pkg::REG_CONFIG) begin
                d.axi.rdata[rsc_pkg::CFG_LOWRES] = q.lowres;
                d.axi.rdata[rsc_pkg::CFG_FAIL] = q.fail_inj;
            end else begin
                d.axi.rresp = rsc_pkg::RESP_SLVERR;
            end
        end
        if (q.axi.rvalid && axi_req.rready) begin
            d.axi.rvalid = 1'b0;
            d.axi.arready = 1'b1;
        end

        // Open drain never drives high
        d.serial_out = 1'b0; // R24
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Storage is volatile here, so power-up always finds it blank
            q <= rsc_pkg::STATE_RESET; // R19 R20 R21 R25
        end else if (ce) begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign axi_rsp = q.axi;
    assign serial_out_o = q.serial_out;
    assign serial_out_oe_n = q.sdo_oe_n;
    assign wiper_o = q.wiper;
    assign shutdown_o = q.shutdown;
    assign tolerance_calib_disable_o = q.ctrl[rsc_pkg::CTL_CAL_DIS];
    assign busy_o = q.busy;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic ce_q;
    always_ff @(posedge clk_sys) begin
        ce_q <= ce;
    end

    wiper_exec_only_a: assert property ( // R3
        $changed(q.wiper) && ce_q |-> $past(exec))
        else $error("wiper changed outside a completed frame");

    wiper_protect_a: assert property ( // R19
        exec && cmd == rsc_pkg::CMD_WRITE_WIPER && !q.ctrl[rsc_pkg::CTL_WRITE_EN]
        |=> $stable(q.wiper))
        else $error("protected wiper was written");

    wiper_load_a: assert property ( // R8
        exec && cmd == rsc_pkg::CMD_WRITE_WIPER && q.ctrl[rsc_pkg::CTL_WRITE_EN] && !q.lowres
        |=> q.wiper == $past(data))
        else $error("wiper write did not load data");

    lowres_mask_a: assert property ( // R6
        exec && cmd == rsc_pkg::CMD_WRITE_WIPER && q.ctrl[rsc_pkg::CTL_WRITE_EN] && q.lowres
        |=> q.wiper[1:0] == 2'h0)
        else $error("low resolution write kept low bits");

    store_refuse_a: assert property ( // R20
        exec && cmd == rsc_pkg::CMD_STORE && !q.ctrl[rsc_pkg::CTL_PROG_EN]
        |=> !q.busy && !q.ctrl[rsc_pkg::CTL_PROG_OK])
        else $error("store ran without program enable");

    store_lock_a: assert property ( // R11
        q.busy && fs_fall && ce |=> q.lstate == rsc_pkg::LS_LOCKED)
        else $error("frame accepted during store");

    short_frame_a: assert property ( // R23
        ce && q.lstate == rsc_pkg::LS_FRAME && fs_rise && !frame_ok
        |=> $stable(q.wiper) && $stable(q.ctrl) && $stable(q.shutdown))
        else $error("short frame changed state");

    shutdown_cmd_a: assert property ( // R18
        exec && cmd == rsc_pkg::CMD_SHUTDOWN |=> q.shutdown == $past(data[0]))
        else $error("shutdown does not follow data bit 0");

    ctrl_write_a: assert property ( // R16
        exec && cmd == rsc_pkg::CMD_WRITE_CTRL |=> q.ctrl[2:0] == $past(data[2:0]))
        else $error("control write mismatch");

    store_cover: cover property (exec && cmd == rsc_pkg::CMD_STORE ##1 q.busy);
    readback_cover: cover property (exec && cmd == rsc_pkg::CMD_READ_WIPER);
    reload_cover: cover property (exec && cmd == rsc_pkg::CMD_RELOAD);
    short_cover: cover property (ce && q.lstate == rsc_pkg::LS_FRAME && fs_rise && !frame_ok);

endmodule // rsc_top

// ==== verification/rsc_host_model.sv ====
// SPI host model that shifts frames into the serial command unit.
// Assumes clk_sys at 100 MHz; link clock period 160 ns.
`timescale 1ns/10ps

module rsc_host_model (
    input wire logic clk_sys,
    input wire logic line,
    output logic sclk,
    output logic frame_sync_n,
    output logic serial_in
);
    initial begin
        sclk = 1'b0;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end

    // Link clock stands still outside frames
    task automatic frame(input int n, input logic [31:0] w, output logic [15:0] rx);
        rx = '0;
        frame_sync_n <= 1'b0;
        repeat (8) @(posedge clk_sys);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in <= w[i];
            sclk <= 1'b1;
            repeat (8) @(posedge clk_sys);
            rx = {rx[14:0], line};
            sclk <= 1'b0;
            repeat (8) @(posedge clk_sys);
        end
        frame_sync_n <= 1'b1;
        serial_in <= ~serial_in;
        repeat (12) @(posedge clk_sys);
    endtask
endmodule // rsc_host_model

// ==== verification/rsc_top_tb.sv ====
// Self-checking bench for the serial command unit.
// Assumes the host model drives the link; this module is the AXI master.
`timescale 1ns/10ps

module rsc_top_tb;
    localparam int unsigned PROG = 2000;
    logic clk_sys;
    logic rst;
    rsc_pkg::rsc_axi_req_type axi_req;
    rsc_pkg::rsc_axi_rsp_type axi_rsp;
    logic sclk, frame_sync_n, serial_in, serial_out_o, serial_out_oe_n;
    logic shutdown_o, tolerance_calib_disable_o, busy_o;
    logic [9:0] wiper_o;
    wire line;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [15:0] rx;
    logic [31:0] rd;
    logic [1:0] rr;

    // Open-drain line with pull-up
    assign line = serial_out_oe_n ? 1'b1 : serial_out_o;

    rsc_top #(.PROG_CYCLES(PROG)) i_dut (.clk_sys(clk_sys), .rst(rst), .ce(1'b1),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .sclk(sclk), .frame_sync_n(frame_sync_n),
        .serial_in(serial_in), .serial_out_i(line), .serial_out_o(serial_out_o),
        .serial_out_oe_n(serial_out_oe_n), .wiper_o(wiper_o), .shutdown_o(shutdown_o),
        .tolerance_calib_disable_o(tolerance_calib_disable_o), .busy_o(busy_o));
    rsc_host_model i_host (.clk_sys(clk_sys), .line(line), .sclk(sclk),
        .frame_sync_n(frame_sync_n), .serial_in(serial_in));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog: a frame is about 300 cycles, the run well under 20000
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        axi_req.awaddr <= a;
        axi_req.wdata <= d;
        axi_req.wstrb <= 4'hf;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (axi_rsp.bvalid !== 1'b1);
        rr = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        axi_req.araddr <= a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (axi_rsp.rvalid !== 1'b1);
        rd = axi_rsp.rdata;
        rr = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic sf(input logic [15:0] w);
        i_host.frame(16, {16'h0000, w}, rx);
    endtask

    task automatic t_reset();
        axi_rd(rsc_pkg::REG_STATUS);
        chk(rd, 32'h0000_0200);
    endtask

    task automatic t_protect();
        sf(16'h0555);
        chk(wiper_o, 10'h200);
        sf(16'h1c03);
        sf(16'h0500);
        chk(wiper_o, 10'h100);
        sf(16'h2000);
        sf(16'h0000);
        chk(rx, 16'h0003);
        chk(tolerance_calib_disable_o, 1'b0);
        sf(16'h0800);
        sf(16'h0000);
        chk(rx, 16'h0100);
    endtask

    task automatic t_frames();
        i_host.frame(12, 32'h0000_0522, rx);
        chk(wiper_o, 10'h100);
        i_host.frame(32, 32'h0000_0522, rx);
        chk(wiper_o, 10'h122);
        sf(16'h0500);
        // Codes 10 to 15, then 0 by wrap
        for (int c = 10; c < 17; c++) begin
            sf({2'b00, 4'(c), 10'h3ff});
            chk(wiper_o, 10'h100);
        end
    endtask

    task automatic t_store();
        sf(16'h0c00);
        chk(busy_o, 1'b1);
        sf(16'h04ff);
        chk(serial_out_oe_n, 1'b1);
        for (int i = 0; i < 5000 && busy_o !== 1'b0; i++) @(posedge clk_sys);
        chk(busy_o, 1'b0);
        chk(wiper_o, 10'h100);
        sf(16'h2000);
        sf(16'h1800);
        chk(rx, 16'h000b);
        sf(16'h1401);
        chk(rx, 16'h0001);
        sf(16'h0000);
        chk(rx, 16'h0100);
    endtask

    task automatic t_axi();
        axi_wr(rsc_pkg::REG_CONFIG, 32'h0000_0001);
        chk(rr, rsc_pkg::RESP_OKAY);
        sf(16'h07ff);
        axi_rd(rsc_pkg::REG_STATUS);
        chk(rd[9:0], 10'h3fc);
        sf(16'h0800);
        sf(16'h0000);
        chk(rx, 16'h03fc);
        axi_wr(8'h08, 32'h0000_0001);
        chk(rr, rsc_pkg::RESP_SLVERR);
        axi_wr(rsc_pkg::REG_STATUS, 32'h0000_0001);
        chk(rr, rsc_pkg::RESP_SLVERR);
        axi_rd(8'h0c);
        chk({rr, rd[29:0]}, {rsc_pkg::RESP_SLVERR, 30'h0});
        axi_wr(rsc_pkg::REG_CONFIG, 32'h0000_0000);
    endtask

    task automatic t_reload();
        sf(16'h0733);
        chk(wiper_o, 10'h333);
        sf(16'h2401);
        chk(shutdown_o, 1'b1);
        sf(16'h2400);
        chk(shutdown_o, 1'b0);
        sf(16'h1c02);
        sf(16'h0c00);
        chk(busy_o, 1'b0);
        sf(16'h2000);
        sf(16'h1c00);
        chk(rx, 16'h0002);
        sf(16'h1000);
        chk(wiper_o, 10'h100);
        sf(16'h1c04);
        chk(tolerance_calib_disable_o, 1'b1);
    endtask

    initial begin
        rst = 1'b1;
        axi_req = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_protect();
        t_frames();
        t_store();
        t_axi();
        t_reload();
        end_of_test();
    end
endmodule // rsc_top_tb
